// ---- rtl/plskt_pkg.sv ----
package plskt_pkg;
	// Instruction encodings (10-bit words)
	localparam logic [9:0] OP_SKIP_TRIG = 10'h03a;
	localparam logic [9:0] OP_SKIP_RESUME = 10'h003;
	localparam int SENSE_SEL_BIT = 2;
	localparam logic SENSE_LOW = 1'h0;
	localparam logic SENSE_HIGH = 1'h1;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	typedef struct packed {
		logic valid;
		logic [9:0] opcode;
	} plskt_instr_t;

	typedef struct packed {
		logic exec_valid;
		logic suppress;
	} plskt_result_t;
endpackage

// ---- rtl/plskt_core.sv ----
`timescale 1ns/1ps
// Contract
// - Select 0: skip next when trigger low
// - Select 1: skip next when trigger high
// - Polarity select is control register bit 2
// - Resume test skips next when flag set
// - Resume test leaves resume flag unchanged
module plskt_core import plskt_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Instruction stream from sequencer
	input wire plskt_instr_t instr,
	// Device state
	input wire logic [3:0] external_trigger_ctrl_reg,
	input wire logic trigger_pin,
	input wire logic standby_resume_flag,
	// Result for the instruction issued one cycle earlier
	output plskt_result_t result,
	output logic skip_taken
);

	logic pin_s1_q, pin_s1_d;
	logic pin_s2_q, pin_s2_d;
	logic skip_pend_q, skip_pend_d;
	plskt_result_t result_q, result_d;
	logic skip_taken_q, skip_taken_d;
	logic ext_level_sense_sel;
	logic cond;

	// Skip polarity for the trigger test
	function automatic logic trig_match(input logic sel, input logic pin);
		trig_match = (sel == SENSE_HIGH) ? pin : ~pin;
	endfunction

	// Opcode decode shared by logic and checks
	function automatic logic is_trig_test(input plskt_instr_t w);
		is_trig_test = (w.opcode == OP_SKIP_TRIG);
	endfunction

	function automatic logic is_resume_test(input plskt_instr_t w);
		is_resume_test = (w.opcode == OP_SKIP_RESUME);
	endfunction

	assign ext_level_sense_sel =
		external_trigger_ctrl_reg[SENSE_SEL_BIT];

	// Two-flop synchroniser for the trigger pin
	always_comb begin
		pin_s1_d = trigger_pin;
		pin_s2_d = pin_s1_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else if (clk_en) begin
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
		end
	end

	// Skip condition of the word on the bus
	always_comb begin
		cond = 1'b0;
		if (is_trig_test(instr)) begin
			cond = trig_match(ext_level_sense_sel, pin_s2_q);
		end else if (is_resume_test(instr)) begin
			// Flag only read, never written
			cond = standby_resume_flag;
		end
	end

	// Pending skip and per-word result
	always_comb begin
		skip_pend_d = skip_pend_q;
		result_d = '0;
		skip_taken_d = 1'b0;
		if (instr.valid) begin
			// Skipped word is consumed but has no effect
			result_d.exec_valid = 1'b1;
			result_d.suppress = skip_pend_q;
			skip_pend_d = ~skip_pend_q & cond;
			skip_taken_d = ~skip_pend_q & cond;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			skip_pend_q <= 1'b0;
			result_q <= '0;
			skip_taken_q <= 1'b0;
		end else if (clk_en) begin
			skip_pend_q <= skip_pend_d;
			result_q <= result_d;
			skip_taken_q <= skip_taken_d;
		end
	end

	assign result = result_q;
	assign skip_taken = skip_taken_q;

	// Trigger level test
	AST_TRIG_LOW: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en && instr.valid && !skip_pend_q && is_trig_test(instr)
		&& external_trigger_ctrl_reg[SENSE_SEL_BIT] == SENSE_LOW
		|=> skip_taken == !$past(pin_s2_q))
		else $error("trigger low skip wrong");

	AST_TRIG_HIGH: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en && instr.valid && !skip_pend_q && is_trig_test(instr)
		&& external_trigger_ctrl_reg[SENSE_SEL_BIT] == SENSE_HIGH
		|=> skip_taken == $past(pin_s2_q))
		else $error("trigger high skip wrong");

	AST_SEL_BIT: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en && instr.valid && !skip_pend_q && is_trig_test(instr)
		|=> skip_taken == ($past(pin_s2_q)
		== $past(external_trigger_ctrl_reg[SENSE_SEL_BIT])))
		else $error("select bit position wrong");

	AST_SYNC_DELAY: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en |=> pin_s2_q == $past(pin_s1_q))
		else $error("pin synchroniser skipped a stage");

	// Standby resume test
	AST_RESUME: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en && instr.valid && !skip_pend_q && is_resume_test(instr)
		|=> skip_taken == $past(standby_resume_flag))
		else $error("resume skip wrong");

	AST_RESUME_CLEAR: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en && instr.valid && !skip_pend_q && is_resume_test(instr)
		&& !standby_resume_flag ##1 clk_en && instr.valid
		|=> result.exec_valid && !result.suppress)
		else $error("resume test skipped with flag clear");

	AST_RESUME_NOSTATE: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en && instr.valid && !skip_pend_q && is_resume_test(instr)
		&& standby_resume_flag
		##1 clk_en && instr.valid
		##1 clk_en && instr.valid && is_resume_test(instr)
		&& standby_resume_flag
		|=> skip_taken)
		else $error("resume test altered state");

	// Suppression and timing
	AST_SUPPRESS_NEXT: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en && instr.valid && skip_pend_d ##1 clk_en && instr.valid
		|=> result.suppress && !skip_taken)
		else $error("skipped word not suppressed");

	AST_ONE_CYCLE: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en && instr.valid |=> result.exec_valid)
		else $error("result not in one cycle");

	AST_NO_CHAIN: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		result.suppress |-> !skip_taken)
		else $error("suppressed word skipped");

	AST_SUPPRESS_VALID: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		result.suppress |-> result.exec_valid)
		else $error("suppress without a word");

	AST_SUPPRESS_ONCE: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en && instr.valid && skip_pend_q |=> !skip_pend_q)
		else $error("skip carried past one word");

	AST_SKIP_MARKS_PEND: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		skip_taken |-> skip_pend_q)
		else $error("skip taken without pending suppress");

	AST_SKIP_FROM_TEST: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		skip_taken && $past(clk_en)
		|-> $past(is_trig_test(instr)) || $past(is_resume_test(instr)))
		else $error("skip from a word that tests nothing");

	AST_OTHER_NO_SKIP: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en && instr.valid && !is_trig_test(instr)
		&& !is_resume_test(instr)
		|=> !skip_taken && !skip_pend_q)
		else $error("non-test word skipped");

	AST_IDLE_QUIET: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		clk_en && !instr.valid
		|=> !result.exec_valid && !result.suppress && !skip_taken)
		else $error("result without a word");

	AST_PEND_HOLD: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!instr.valid |=> skip_pend_q == $past(skip_pend_q))
		else $error("pending skip lost between words");

	// Clock enable and reset
	AST_FREEZE: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!clk_en |=> $stable(result) && $stable(skip_taken)
		&& $stable(skip_pend_q))
		else $error("state moved while frozen");

	AST_RESET_CLEAR: assert property (
		@(posedge sys_clk)
		!nrst |=> !result.exec_valid && !result.suppress && !skip_taken
		&& !skip_pend_q)
		else $error("reset left a result");
endmodule

// ---- verification/tb_pin_level_skip_test.sv ----
`timescale 1ns/1ps
module tb_pin_level_skip_test import plskt_pkg::*;;
	logic sys_clk = 0, nrst = 0, clk_en = 1, trigger_pin = 0;
	logic standby_resume_flag = 0, skip_taken, pend = 0, sel = 0, t;
	logic [3:0] ctrl = CTRL_RESET;
	plskt_instr_t instr = '0;
	plskt_result_t result;
	logic [2:0] exp_q[$];
	logic [2:0] obs, want, prev = 3'h0;
	logic fresh = 1'b0;
	logic [31:0] lfsr = 32'h8159;
	int error_cnt = 0, check_count = 0;
	always #5 sys_clk = ~sys_clk;
	plskt_core dut(.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
		.instr(instr), .external_trigger_ctrl_reg(ctrl),
		.trigger_pin(trigger_pin), .standby_resume_flag(standby_resume_flag),
		.result(result), .skip_taken(skip_taken));
	function automatic logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(logic [2:0] seen, logic [2:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t saw %b want %b", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// A frozen edge must not yield a second result
	always @(posedge sys_clk) fresh <= clk_en;
	// Oldest note pairs with each completed word
	always @(negedge sys_clk) if (nrst) begin
		obs = {result, skip_taken};
		if (!fresh) begin
			chk(obs, prev);
		end else if (result.exec_valid === 1'b1) begin
			want = exp_q.size() ? exp_q.pop_front() : 3'h0;
			chk(obs, want);
		end
		prev = obs;
	end
	initial begin
		repeat (16) @(negedge sys_clk);
		nrst = 1;
		for (int g = 0; g < 40; g++) begin
			if (g == 20) begin
				// Mid-run reset drops any pending skip
				@(negedge sys_clk);
				nrst = 0;
				repeat (2) @(negedge sys_clk);
				chk({result, skip_taken}, 3'h0);
				nrst = 1;
				pend = 0;
			end
			lfsr = nxt(lfsr);
			sel = lfsr[3];
			trigger_pin = lfsr[4];
			standby_resume_flag = lfsr[5];
			ctrl = {lfsr[9], sel, lfsr[8:7]};
			// Idle gap lets the pin synchroniser settle
			repeat (4) @(negedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				lfsr = nxt(lfsr);
				instr.valid = 1;
				instr.opcode = lfsr[1:0] == 2'h1 ? OP_SKIP_RESUME :
					lfsr[1:0] == 2'h3 ? lfsr[15:6] : OP_SKIP_TRIG;
				t = (instr.opcode == OP_SKIP_TRIG && trigger_pin == sel) ||
					(instr.opcode == OP_SKIP_RESUME && standby_resume_flag);
				exp_q.push_back({1'b1, pend, ~pend & t});
				pend = ~pend & t;
				if (lfsr[20]) begin
					// Frozen edge: word waits, result stands
					clk_en = 0;
					@(negedge sys_clk);
					clk_en = 1;
				end
				@(negedge sys_clk);
			end
			instr.valid = 0;
			$display("group %0d done", g);
		end
		repeat (3) @(negedge sys_clk);
		if (exp_q.size() != 0)
			chk(3'h0, 3'h7);
		give_verdict();
	end
endmodule
